/* File: inc/sev_pkg.sv */
// Constants, enumerations and carrier structs of the segment extension block.
// Assumes an 8-bit register file port and a CPU core that sequences its own pipeline.
package sev_pkg;
   localparam int         SEG_W         = 6;
   localparam logic [7:0] ADR_DPR0      = 8'hF0;
   localparam logic [7:0] ADR_DPR0_REL  = 8'hE0;
   localparam logic [7:0] ADR_CODE      = 8'hF4;
   localparam logic [7:0] ADR_EXTENDED_MODE_REG_TWO      = 8'hF6;
   localparam logic [7:0] ADR_ISEG      = 8'hF8;
   localparam logic [7:0] ADR_DSEG      = 8'hF9;
   localparam int         EXTENDED_MODE_REG_TWO_RELOC    = 5;
   localparam int         EXTENDED_MODE_REG_TWO_EXT      = 6;
   localparam logic [5:0] CODE_SEG_RST  = 6'h00;
   // The interrupt and DMA segments are undefined after reset; zero is arbitrary.
   localparam logic [5:0] SEG_UNDEF_RST = 6'h00;
   localparam logic [5:0] SEG_ZERO      = 6'h00;
   localparam logic [15:0] VEC_RST_OFF  = 16'h0000;
   localparam logic [15:0] VEC_TRAP_OFF = 16'h0002;
   localparam logic [15:0] VEC_TOP_OFF  = 16'h0004;
   localparam logic [7:0]  VEC_PAGE_HI  = 8'h00;
   localparam logic [1:0]  RSVD_ZERO    = 2'b00;
   localparam logic [3:0]  DEPTH_ONE    = 4'h1;

   typedef enum logic [1:0] {
      A_FETCH = 2'b00,
      A_DATA  = 2'b01,
      A_DMA   = 2'b10,
      A_VECT  = 2'b11
   } sev_acc_e;

   typedef enum logic [1:0] {
      K_RST  = 2'b00,
      K_INT  = 2'b01,
      K_TOP  = 2'b10,
      K_TRAP = 2'b11
   } sev_kind_e;

   typedef enum logic [3:0] {
      S_IDLE  = 4'b0000,
      S_P_PCL = 4'b0001,
      S_P_PCH = 4'b0010,
      S_P_CSR = 4'b0011,
      S_P_FLG = 4'b0100,
      S_V_LO  = 4'b0101,
      S_V_HI  = 4'b0110,
      S_R_FLG = 4'b0111,
      S_R_CSR = 4'b1000,
      S_R_PCH = 4'b1001,
      S_R_PCL = 4'b1010
   } sev_fsm_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       page21;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sev_rf_req_s;

   typedef struct packed {
      logic [5:0]      code;
      logic [5:0]      intr;
      logic [5:0]      dma;
      logic            dma_sel;
      logic [5:0]      vec;
      logic [3:0][7:0] page;
   } sev_map_s;

   typedef struct packed {
      sev_fsm_e        state;
      sev_kind_e       kind;
      logic [5:0]      code_segment;
      logic [5:0]      interrupt_segment;
      logic [5:0]      dsr;
      logic [3:0][7:0] page;
      logic            reloc;
      logic            ext;
      logic [3:0]      depth;
      logic [15:0]     pc;
      logic [7:0]      flags;
      logic [7:0]      vec;
      logic            nmi_s1;
      logic            nmi_s2;
      logic            top_req;
      logic [7:0]      rdata;
      logic            push;
      logic            pop;
      logic [7:0]      sdata;
      logic            vec_rd;
      logic            pc_ld;
      logic            flg_ld;
      logic [15:0]     pc_out;
      logic [7:0]      flg_out;
      logic            busy;
   } sev_top_s;
endpackage : sev_pkg

/* File: verilog/sev_addr_gen.sv */
// Registered physical address former: picks the upper bits by access type.
// Assumes the segment map is stable in the cycle of the access.
`timescale 1ns/100ps
module sev_addr_gen (
   input  wire logic                i_clk,
   input  wire logic                i_reset_n,
   input  wire sev_pkg::sev_acc_e   i_acc,
   input  wire logic [15:0]         i_vaddr,
   input  wire sev_pkg::sev_map_s   i_map,
   output logic [21:0]              o_phys
);
   logic [21:0] phys_reg;
   logic [21:0] phys_next;

   always_comb
   begin
      case (i_acc)
         sev_pkg::A_FETCH: phys_next = {i_map.code, i_vaddr};
         sev_pkg::A_DATA:  phys_next = {i_map.page[i_vaddr[15:14]], i_vaddr[13:0]};
         sev_pkg::A_DMA:   phys_next = {i_map.dma_sel ? i_map.dma : i_map.intr, i_vaddr};
         default:          phys_next = {i_map.vec, i_vaddr};
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         phys_reg <= '0;
      else
         phys_reg <= phys_next;
   end

   assign o_phys = phys_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   chk_fetch_seg: assert property (
      i_acc == sev_pkg::A_FETCH |=> o_phys == {$past(i_map.code), $past(i_vaddr)})
      else $error("fetch address segment wrong");
   chk_dma_seg: assert property (
      i_acc == sev_pkg::A_DMA |=> o_phys[21:16] == ($past(i_map.dma_sel) ? $past(i_map.dma) : $past(i_map.intr)))
      else $error("dma segment select wrong");
   chk_data_page: assert property (
      i_acc == sev_pkg::A_DATA |=> o_phys[21:14] == $past(i_map.page[i_vaddr[15:14]]))
      else $error("data page mapping wrong");
   cov_dma_sel: cover property (i_acc == sev_pkg::A_DMA && i_map.dma_sel);
endmodule : sev_addr_gen

/* File: verilog/sev_top.sv */
// Segment extension and interrupt vectoring logic of the memory management unit.
// Assumes the core raises one-cycle request pulses only while O_BUSY is low,
// and presents popped stack bytes on I_POP_DATA in every cycle that O_STK_POP is high.
`timescale 1ns/100ps
module sev_top (
   input  wire logic                  I_CORE_CLK,
   input  wire logic                  I_RESET_N,
   input  wire sev_pkg::sev_rf_req_s  I_RF_REQ,
   output logic [7:0]                 O_RF_RDATA,
   input  wire sev_pkg::sev_acc_e     I_ACC_TYPE,
   input  wire logic [15:0]           I_VADDR,
   input  wire logic                  I_DMA_SEL,
   input  wire logic [15:0]           I_PC,
   input  wire logic [7:0]            I_FLAGS,
   input  wire logic                  I_INT_ACK,
   input  wire logic                  I_INT_TOP,
   input  wire logic [7:0]            I_VEC_BASE,
   input  wire logic [7:0]            I_VEC_MASK,
   input  wire logic [7:0]            I_VEC_CHAN,
   input  wire logic                  I_DIV0_TRAP,
   input  wire logic                  I_IRET,
   input  wire logic                  I_FAR_LOAD,
   input  wire logic [5:0]            I_FAR_SEG,
   input  wire logic [7:0]            I_POP_DATA,
   input  wire logic                  I_NMI_PIN,
   input  wire logic                  I_WDT_REQ,
   input  wire logic                  I_TOP_SRC_WDT,
   output logic [21:0]                O_PHYS_ADDR,
   output logic                       O_VEC_RD,
   output logic                       O_STK_PUSH,
   output logic                       O_STK_POP,
   output logic [7:0]                 O_STK_DATA,
   output logic                       O_PC_LOAD,
   output logic [15:0]                O_PC_VALUE,
   output logic                       O_FLAGS_LOAD,
   output logic [7:0]                 O_FLAGS_VALUE,
   output logic [5:0]                 O_CODE_SEG,
   output logic                       O_PORT_REMAP,
   output logic                       O_EXT_FRAME,
   output logic                       O_TOP_REQ,
   output logic                       O_BUSY
);
   localparam sev_pkg::sev_top_s ST_RST = '{
      state:   sev_pkg::S_V_LO,
      kind:    sev_pkg::K_RST,
      code_segment:     sev_pkg::CODE_SEG_RST,
      interrupt_segment:     sev_pkg::SEG_UNDEF_RST,
      dsr:     sev_pkg::SEG_UNDEF_RST,
      busy:    1'b1,
      default: '0
   };

   sev_pkg::sev_top_s st_reg;
   sev_pkg::sev_top_s st_next;
   sev_pkg::sev_map_s map;
   sev_pkg::sev_acc_e acc;
   logic [15:0]       vaddr;
   logic [15:0]       vec_base;
   logic [5:0]        code_eff;
   logic              hit_dpr;
   logic              hit_p21;
   logic [7:0]        rd_val;

   // While the compatible-frame depth is nonzero the interrupt segment stands in for the code segment.
   assign code_eff = (st_reg.depth != '0) ? st_reg.interrupt_segment : st_reg.code_segment;

   always_comb
   begin
      case (st_reg.kind)
         sev_pkg::K_RST:  vec_base = sev_pkg::VEC_RST_OFF;
         sev_pkg::K_TOP:  vec_base = sev_pkg::VEC_TOP_OFF;
         sev_pkg::K_TRAP: vec_base = sev_pkg::VEC_TRAP_OFF;
         default:         vec_base = {sev_pkg::VEC_PAGE_HI, st_reg.vec};
      endcase
   end

   always_comb
   begin
      map.code    = code_eff;
      map.intr    = st_reg.interrupt_segment;
      map.dma     = st_reg.dsr;
      map.dma_sel = I_DMA_SEL;
      map.page    = st_reg.page;
      if (st_reg.kind == sev_pkg::K_RST)
         map.vec = sev_pkg::SEG_ZERO;
      else if (st_reg.kind == sev_pkg::K_TRAP)
         map.vec = code_eff;
      else
         map.vec = st_reg.interrupt_segment;
      if (st_reg.state == sev_pkg::S_V_LO || st_reg.state == sev_pkg::S_V_HI)
      begin
         acc   = sev_pkg::A_VECT;
         // The high byte is the next address, so an odd channel vector still reads a true pair.
         vaddr = vec_base + {15'h0000, st_reg.state == sev_pkg::S_V_HI};
      end
      else
      begin
         acc   = I_ACC_TYPE;
         vaddr = I_VADDR;
      end
   end

   sev_addr_gen u_addr (
      .i_clk     (I_CORE_CLK),
      .i_reset_n (I_RESET_N),
      .i_acc     (acc),
      .i_vaddr   (vaddr),
      .i_map     (map),
      .o_phys    (O_PHYS_ADDR)
   );

   // Page registers move to group E, which is not paged, once relocation is on.
   assign hit_p21 = I_RF_REQ.page21;
   assign hit_dpr = st_reg.reloc ? (I_RF_REQ.addr[7:2] == sev_pkg::ADR_DPR0_REL[7:2])
                                 : (hit_p21 && I_RF_REQ.addr[7:2] == sev_pkg::ADR_DPR0[7:2]);

   always_comb
   begin
      rd_val = '0;
      if (hit_dpr)
         rd_val = st_reg.page[I_RF_REQ.addr[1:0]];
      else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_CODE)
         rd_val = {sev_pkg::RSVD_ZERO, st_reg.code_segment};
      else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_EXTENDED_MODE_REG_TWO)
      begin
         rd_val[sev_pkg::EXTENDED_MODE_REG_TWO_RELOC] = st_reg.reloc;
         rd_val[sev_pkg::EXTENDED_MODE_REG_TWO_EXT]   = st_reg.ext;
      end
      else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_ISEG)
         rd_val = {sev_pkg::RSVD_ZERO, st_reg.interrupt_segment};
      else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_DSEG)
         rd_val = {sev_pkg::RSVD_ZERO, st_reg.dsr};
   end

   always_comb
   begin
      st_next        = st_reg;
      st_next.push   = 1'b0;
      st_next.pop    = 1'b0;
      st_next.vec_rd = 1'b0;
      st_next.pc_ld  = 1'b0;
      st_next.flg_ld = 1'b0;
      st_next.nmi_s1 = I_NMI_PIN;
      st_next.nmi_s2 = st_reg.nmi_s1;
      st_next.top_req = I_TOP_SRC_WDT ? I_WDT_REQ : st_reg.nmi_s2;
      if (I_RF_REQ.rd)
         st_next.rdata = rd_val;
      // Only six segment bits are stored; bits 7:6 read back as zero.
      if (I_RF_REQ.wr)
      begin
         if (hit_dpr)
            st_next.page[I_RF_REQ.addr[1:0]] = I_RF_REQ.wdata;
         else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_CODE)
            st_next.code_segment = I_RF_REQ.wdata[5:0];
         else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_EXTENDED_MODE_REG_TWO)
         begin
            st_next.reloc = I_RF_REQ.wdata[sev_pkg::EXTENDED_MODE_REG_TWO_RELOC];
            st_next.ext   = I_RF_REQ.wdata[sev_pkg::EXTENDED_MODE_REG_TWO_EXT];
         end
         else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_ISEG)
            st_next.interrupt_segment = I_RF_REQ.wdata[5:0];
         else if (hit_p21 && I_RF_REQ.addr == sev_pkg::ADR_DSEG)
            st_next.dsr = I_RF_REQ.wdata[5:0];
      end
      if (I_FAR_LOAD)
         st_next.code_segment = I_FAR_SEG;
      case (st_reg.state)
         sev_pkg::S_IDLE:
         begin
            if (I_IRET)
            begin
               st_next.state = sev_pkg::S_R_FLG;
               st_next.pop   = 1'b1;
            end
            else if (I_INT_ACK || I_DIV0_TRAP)
            begin
               if (I_INT_ACK)
                  st_next.kind = I_INT_TOP ? sev_pkg::K_TOP : sev_pkg::K_INT;
               else
                  st_next.kind = sev_pkg::K_TRAP;
               st_next.pc    = I_PC;
               st_next.flags = I_FLAGS;
               st_next.vec   = (I_VEC_BASE & ~I_VEC_MASK) | (I_VEC_CHAN & I_VEC_MASK);
               st_next.state = sev_pkg::S_P_PCL;
               st_next.push  = 1'b1;
               st_next.sdata = I_PC[7:0];
            end
         end
         sev_pkg::S_P_PCL:
         begin
            st_next.state = sev_pkg::S_P_PCH;
            st_next.push  = 1'b1;
            st_next.sdata = st_reg.pc[15:8];
         end
         sev_pkg::S_P_PCH:
         begin
            if (st_reg.kind == sev_pkg::K_TRAP)
               st_next.state = sev_pkg::S_V_LO;
            else if (st_reg.ext)
            begin
               st_next.state = sev_pkg::S_P_CSR;
               st_next.push  = 1'b1;
               st_next.sdata = {sev_pkg::RSVD_ZERO, st_reg.code_segment};
            end
            else
            begin
               st_next.state = sev_pkg::S_P_FLG;
               st_next.push  = 1'b1;
               st_next.sdata = st_reg.flags;
            end
         end
         sev_pkg::S_P_CSR:
         begin
            st_next.state = sev_pkg::S_P_FLG;
            st_next.push  = 1'b1;
            st_next.sdata = st_reg.flags;
         end
         sev_pkg::S_P_FLG:
         begin
            st_next.state = sev_pkg::S_V_LO;
            if (st_reg.ext)
               st_next.code_segment = st_reg.interrupt_segment;
            else
               st_next.depth = st_reg.depth + sev_pkg::DEPTH_ONE;
         end
         sev_pkg::S_V_LO:
         begin
            st_next.state  = sev_pkg::S_V_HI;
            st_next.vec_rd = 1'b1;
         end
         sev_pkg::S_V_HI:
         begin
            st_next.state  = sev_pkg::S_IDLE;
            st_next.vec_rd = 1'b1;
         end
         sev_pkg::S_R_FLG:
         begin
            st_next.flg_out = I_POP_DATA;
            st_next.flg_ld  = 1'b1;
            st_next.pop     = 1'b1;
            st_next.state   = st_reg.ext ? sev_pkg::S_R_CSR : sev_pkg::S_R_PCH;
         end
         sev_pkg::S_R_CSR:
         begin
            st_next.code_segment   = I_POP_DATA[5:0];
            st_next.pop   = 1'b1;
            st_next.state = sev_pkg::S_R_PCH;
         end
         sev_pkg::S_R_PCH:
         begin
            st_next.pc_out[15:8] = I_POP_DATA;
            st_next.pop          = 1'b1;
            st_next.state        = sev_pkg::S_R_PCL;
         end
         sev_pkg::S_R_PCL:
         begin
            st_next.pc_out[7:0] = I_POP_DATA;
            st_next.pc_ld       = 1'b1;
            st_next.state       = sev_pkg::S_IDLE;
            if (!st_reg.ext && st_reg.depth != '0)
               st_next.depth = st_reg.depth - sev_pkg::DEPTH_ONE;
         end
         default:
            st_next.state = sev_pkg::S_IDLE;
      endcase
      st_next.busy = (st_next.state != sev_pkg::S_IDLE);
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         st_reg <= ST_RST;
      else
         st_reg <= st_next;
   end

   assign O_RF_RDATA    = st_reg.rdata;
   assign O_VEC_RD      = st_reg.vec_rd;
   assign O_STK_PUSH    = st_reg.push;
   assign O_STK_POP     = st_reg.pop;
   assign O_STK_DATA    = st_reg.sdata;
   assign O_PC_LOAD     = st_reg.pc_ld;
   assign O_PC_VALUE    = st_reg.pc_out;
   assign O_FLAGS_LOAD  = st_reg.flg_ld;
   assign O_FLAGS_VALUE = st_reg.flg_out;
   assign O_CODE_SEG    = st_reg.code_segment;
   assign O_PORT_REMAP  = st_reg.reloc;
   assign O_EXT_FRAME   = st_reg.ext;
   assign O_TOP_REQ     = st_reg.top_req;
   assign O_BUSY        = st_reg.busy;

   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RESET_N);

   chk_push_order: assert property (
      st_reg.state == sev_pkg::S_P_PCL |-> O_STK_PUSH && O_STK_DATA == st_reg.pc[7:0]
         ##1 O_STK_PUSH && O_STK_DATA == st_reg.pc[15:8])
      else $error("program counter pushed out of order");
   chk_compat_frame: assert property (
      st_reg.state == sev_pkg::S_P_PCH && !st_reg.ext && st_reg.kind != sev_pkg::K_TRAP
         |=> st_reg.state == sev_pkg::S_P_FLG ##1 st_reg.state == sev_pkg::S_V_LO)
      else $error("compatible frame holds extra bytes");
   chk_ext_frame: assert property (
      st_reg.state == sev_pkg::S_P_PCH && st_reg.ext && st_reg.kind != sev_pkg::K_TRAP
         |=> O_STK_DATA[5:0] == $past(st_reg.code_segment) ##1 st_reg.state == sev_pkg::S_P_FLG
         ##1 st_reg.code_segment == $past(st_reg.interrupt_segment))
      else $error("extended entry frame or segment load wrong");
   chk_iret_csr: assert property (
      st_reg.state == sev_pkg::S_R_CSR && !I_FAR_LOAD |=> st_reg.code_segment == $past(I_POP_DATA[5:0]))
      else $error("code segment not restored on return");
   chk_trap_frame: assert property (
      st_reg.state == sev_pkg::S_P_PCH && st_reg.kind == sev_pkg::K_TRAP
         |=> !O_STK_PUSH && st_reg.state == sev_pkg::S_V_LO)
      else $error("trap pushed flags");
   chk_top_vector: assert property (
      st_reg.state == sev_pkg::S_V_LO && st_reg.kind == sev_pkg::K_TOP
         |=> O_VEC_RD && O_PHYS_ADDR == {$past(st_reg.interrupt_segment), sev_pkg::VEC_TOP_OFF}
         ##1 O_VEC_RD && O_PHYS_ADDR[15:0] == (sev_pkg::VEC_TOP_OFF | 16'h0001))
      else $error("top-level vector address wrong");
   chk_trap_vector: assert property (
      st_reg.state == sev_pkg::S_V_LO && st_reg.kind == sev_pkg::K_TRAP
         |=> O_PHYS_ADDR == {$past(code_eff), sev_pkg::VEC_TRAP_OFF})
      else $error("trap vector address wrong");
   chk_reset_vector: assert property (
      st_reg.state == sev_pkg::S_V_LO && st_reg.kind == sev_pkg::K_RST |=> O_PHYS_ADDR == '0 && O_VEC_RD)
      else $error("reset vector not at physical zero");
   chk_far_load: assert property (
      I_FAR_LOAD && st_reg.state == sev_pkg::S_IDLE |=> O_CODE_SEG == $past(I_FAR_SEG))
      else $error("far transfer did not load code segment");
   chk_top_source: assert property (
      I_TOP_SRC_WDT && I_WDT_REQ |=> O_TOP_REQ)
      else $error("watchdog not routed to top channel");

   cov_ext_entry: cover property (st_reg.state == sev_pkg::S_P_CSR);
   cov_compat_ret: cover property (st_reg.state == sev_pkg::S_R_PCL && st_reg.depth != '0);
   cov_trap: cover property (st_reg.kind == sev_pkg::K_TRAP && st_reg.state == sev_pkg::S_V_HI);
   cov_reloc: cover property (st_reg.reloc && I_RF_REQ.wr && hit_dpr);
endmodule : sev_top

/* File: verif/sev_stack_model.sv */
// Behavioural system stack of the core, fed by the block's push and pop strobes.
// Assumes strobes and data are registered outputs that change on the rising edge.
`timescale 1ns/100ps
module sev_stack_model (
   input  wire logic       i_clk,
   input  wire logic       i_flush,
   input  wire logic       i_push,
   input  wire logic       i_pop,
   input  wire logic [7:0] i_data,
   output logic [7:0]      o_data
);
   logic [7:0] mem[$];
   logic [7:0] top_b = 8'h00;
   logic [7:0] idle_p = 8'h5A;
   int         depth = 0;
   logic       ps, pp, fl;
   logic [7:0] d;

   // Outside a pop the line changes every cycle, so a stale byte cannot pass for data.
   assign o_data = (i_pop && depth != 0) ? top_b : idle_p;

   always @(posedge i_clk)
   begin
      {ps, pp, fl, d} = {i_push, i_pop, i_flush, i_data};
      #1;
      idle_p = ~idle_p;
      if (fl)
         mem.delete();
      else if (ps)
         mem.push_back(d);
      else if (pp && depth != 0)
         void'(mem.pop_back());
      depth = mem.size();
      top_b = depth != 0 ? mem[depth - 1] : 8'h00;
   end
endmodule : sev_stack_model

/* File: verif/sev_top_tb.sv */
// Self-checking bench of the segment block against a small reference model.
// Assumes sev_stack_model plays the core's system stack.
`timescale 1ns/100ps
module sev_top_tb;
   logic                 clk, rst_n, dsel, ack, top, trap, iret, far, nmi, wdt, src, fl;
   logic                 vrd, push, pop, remap, ext, topq, busy, fld, pld;
   sev_pkg::sev_rf_req_s rf;
   sev_pkg::sev_acc_e    acc;
   logic [7:0]           rdata, pop_d, stk_d, flg, flg_v, vbase, vmask, vchan, rb;
   logic [15:0]          vaddr, pc, pc_v, off;
   logic [5:0]           far_seg, cseg;
   logic [21:0]          phys;
   integer               n_errors, check_count, seed, i;
   int                   m_iseg, m_dseg, m_page, m_cseg, m_ext;
   logic [7:0]           exp_q[$];

   sev_top sev_top_i (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_RF_REQ(rf), .O_RF_RDATA(rdata),
      .I_ACC_TYPE(acc), .I_VADDR(vaddr), .I_DMA_SEL(dsel), .I_PC(pc), .I_FLAGS(flg), .I_INT_ACK(ack),
      .I_INT_TOP(top), .I_VEC_BASE(vbase), .I_VEC_MASK(vmask), .I_VEC_CHAN(vchan), .I_DIV0_TRAP(trap),
      .I_IRET(iret), .I_FAR_LOAD(far), .I_FAR_SEG(far_seg), .I_POP_DATA(pop_d), .I_NMI_PIN(nmi),
      .I_WDT_REQ(wdt), .I_TOP_SRC_WDT(src), .O_PHYS_ADDR(phys), .O_VEC_RD(vrd), .O_STK_PUSH(push),
      .O_STK_POP(pop), .O_STK_DATA(stk_d), .O_PC_LOAD(pld), .O_PC_VALUE(pc_v), .O_FLAGS_LOAD(fld),
      .O_FLAGS_VALUE(flg_v), .O_CODE_SEG(cseg), .O_PORT_REMAP(remap), .O_EXT_FRAME(ext),
      .O_TOP_REQ(topq), .O_BUSY(busy));
   sev_stack_model stk_i (.i_clk(clk), .i_flush(fl), .i_push(push), .i_pop(pop), .i_data(stk_d),
      .o_data(pop_d));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   task automatic cmp_addr(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp_addr

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_addr({16'h0000, got}, {16'h0000, exp});
   endtask : cmp_byte

   task automatic rf_op(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      step;
      rf = '{wr: wr, rd: !wr, page21: 1'b1, addr: a, wdata: wd};
      step;
      rd = rdata;
      rf = '0;
   endtask : rf_op

   task automatic xlate(input sev_pkg::sev_acc_e a, input logic s, input int seg);
      step;
      acc = a;
      dsel = s;
      vaddr = 16'($random(seed));
      if (a == sev_pkg::A_DATA)
         vaddr[15:14] = 2'b00;
      step;
      cmp_addr({2'b00, phys}, a == sev_pkg::A_DATA ? {2'b00, seg[7:0], vaddr[13:0]} : {2'b00, seg[5:0], vaddr});
   endtask : xlate

   task automatic wait_idle;
      i = 0;
      while (busy !== 1'b0 && i < 40)
      begin
         step;
         i++;
      end
      cmp_byte({7'h00, busy}, 8'h00);
   endtask : wait_idle

   // Kind 0 is a peripheral interrupt, 1 the top-level channel, 2 the divide trap.
   task automatic enter(input int kind);
      int seg;
      step;
      pc = 16'($random(seed));
      flg = 8'($random(seed));
      vchan = 8'($random(seed));
      {ack, top, trap} = {kind != 2, kind == 1, kind == 2};
      off = kind == 2 ? 16'h0002 : kind == 1 ? 16'h0004 : {8'h00, (vbase & ~vmask) | (vchan & vmask)};
      seg = kind == 2 ? m_cseg : m_iseg;
      exp_q = {pc[7:0], pc[15:8]};
      if (m_ext == 1 && kind != 2)
         exp_q.push_back(8'(m_cseg));
      if (kind != 2)
         exp_q.push_back(flg);
      step;
      {ack, top, trap} = 3'b000;
      i = 0;
      while (vrd !== 1'b1 && i < 20)
      begin
         step;
         i++;
      end
      cmp_addr({2'b00, phys}, {2'b00, seg[5:0], off});
      step;
      cmp_addr({2'b00, phys}, {2'b00, seg[5:0], off + 16'h0001});
      cmp_byte(8'(stk_i.mem.size()), 8'(exp_q.size()));
      foreach (exp_q[k])
         cmp_byte(stk_i.mem[k], exp_q[k]);
      wait_idle;
   endtask : enter

   task automatic leave;
      step;
      iret = 1'b1;
      step;
      iret = 1'b0;
      step;
      cmp_byte({7'h00, fld}, 8'h01);
      wait_idle;
      cmp_byte({7'h00, pld}, 8'h01);
      cmp_byte(flg_v, flg);
      cmp_addr({8'h00, pc_v}, {8'h00, pc});
   endtask : leave

   task automatic end_test(input string s);
      $display("Test %s done", s);
   endtask : end_test

   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report

   initial
   begin
      repeat (4000) @(posedge clk);
      n_errors++;
      final_report;
   end

   initial
   begin
      {n_errors, check_count, m_cseg, m_ext} = '0;
      seed = 32'h6c5d_8a80;
      {rst_n, dsel, ack, top, trap, iret, far, nmi, wdt, src, fl} = '0;
      {rf, vaddr, pc, flg, vchan, far_seg} = '0;
      acc = sev_pkg::A_FETCH;
      vbase = 8'hA5;
      vmask = 8'h0F;
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      step;
      cmp_addr({1'b0, vrd, phys}, 24'h40_0000);
      step;
      cmp_addr({1'b0, vrd, phys}, 24'h40_0001);
      cmp_byte({2'b00, cseg}, 8'h00);
      m_iseg = $random(seed) & 32'h0000_003F;
      m_dseg = $random(seed) & 32'h0000_003F;
      m_page = $random(seed) & 32'h0000_00FF;
      rf_op(1'b1, sev_pkg::ADR_ISEG, m_iseg[7:0], rb);
      rf_op(1'b1, sev_pkg::ADR_DSEG, m_dseg[7:0], rb);
      rf_op(1'b1, sev_pkg::ADR_DPR0, m_page[7:0], rb);
      rf_op(1'b0, sev_pkg::ADR_ISEG, 8'h00, rb);
      cmp_byte(rb, m_iseg[7:0]);
      rf_op(1'b0, sev_pkg::ADR_DSEG, 8'h00, rb);
      cmp_byte(rb, m_dseg[7:0]);
      rf_op(1'b0, 8'hF7, 8'h00, rb);
      cmp_byte(rb, 8'h00);
      end_test("registers");
      for (int n = 0; n < 4; n++)
      begin
         xlate(sev_pkg::A_DMA, 1'b0, m_iseg);
         xlate(sev_pkg::A_DMA, 1'b1, m_dseg);
         xlate(sev_pkg::A_FETCH, 1'b0, m_cseg);
         xlate(sev_pkg::A_DATA, 1'b0, m_page);
      end
      step;
      {src, wdt} = 2'b11;
      step;
      cmp_byte({7'h00, topq}, 8'h01);
      {src, wdt, nmi} = 3'b001;
      repeat (3) step;
      cmp_byte({7'h00, topq}, 8'h01);
      nmi = 1'b0;
      end_test("address select");
      enter(0);
      xlate(sev_pkg::A_FETCH, 1'b0, m_iseg);
      leave;
      xlate(sev_pkg::A_FETCH, 1'b0, m_cseg);
      enter(1);
      leave;
      enter(2);
      step;
      fl = 1'b1;
      step;
      fl = 1'b0;
      end_test("compatible frame");
      far_seg = m_iseg[5:0] ^ 6'h15;
      m_cseg = far_seg;
      far = 1'b1;
      step;
      far = 1'b0;
      cmp_byte({2'b00, cseg}, m_cseg[7:0]);
      rf_op(1'b1, sev_pkg::ADR_EXTENDED_MODE_REG_TWO, 8'h40, rb);
      m_ext = 1;
      cmp_byte({6'h00, remap, ext}, 8'h01);
      enter(0);
      cmp_byte({2'b00, cseg}, m_iseg[7:0]);
      rf_op(1'b1, sev_pkg::ADR_DPR0, m_page[7:0] ^ 8'h3C, rb);
      xlate(sev_pkg::A_DATA, 1'b0, m_page ^ 8'h3C);
      rf_op(1'b1, sev_pkg::ADR_DPR0, m_page[7:0], rb);
      leave;
      cmp_byte({2'b00, cseg}, m_cseg[7:0]);
      rf_op(1'b1, sev_pkg::ADR_EXTENDED_MODE_REG_TWO, 8'h20, rb);
      m_ext = 0;
      cmp_byte({6'h00, remap, ext}, 8'h02);
      rf_op(1'b0, sev_pkg::ADR_EXTENDED_MODE_REG_TWO, 8'h00, rb);
      cmp_byte(rb, 8'h20);
      rf_op(1'b1, sev_pkg::ADR_DPR0_REL, m_page[7:0] ^ 8'h5A, rb);
      xlate(sev_pkg::A_DATA, 1'b0, m_page ^ 8'h5A);
      rf_op(1'b0, sev_pkg::ADR_DPR0, 8'h00, rb);
      cmp_byte(rb, 8'h00);
      end_test("extended frame");
      final_report;
   end
endmodule : sev_top_tb
